// ### verilog/mic_pkg.sv
// Constants shared by the metering interrupt and configuration logic.
package mic_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_MAX = 24;
   localparam int LEN_W = 5;
   localparam logic [LEN_W-1:0] COMM_LEN = 5'h08;
   localparam int CMD_WRITE_BIT = 7;
   localparam logic [ADDR_W-1:0] ADR_WAVE = 6'h01;
   localparam logic [ADDR_W-1:0] ADR_MODE = 6'h09;
   localparam logic [ADDR_W-1:0] ADR_IRQ_EN = 6'h0a;
   localparam logic [ADDR_W-1:0] ADR_FLAGS = 6'h0b;
   localparam logic [ADDR_W-1:0] ADR_FLAGS_RC = 6'h0c;
   localparam logic [ADDR_W-1:0] ADR_CHANNEL_ONE_OFFSET_INTEGRATOR = 6'h0d;
   localparam logic [LEN_W-1:0] LEN_24 = 5'h18;
   localparam logic [LEN_W-1:0] LEN_16 = 5'h10;
   localparam logic [LEN_W-1:0] LEN_8 = 5'h08;
   localparam logic [15:0] MODE_RST = 16'h000c;
   localparam int MODE_TEMP_BIT = 5;
   localparam int MODE_SWRST_BIT = 6;
   localparam int WAVEFORM_SOURCE_SELECT_LSB = 13;
   localparam int WAVEFORM_SOURCE_SELECT_MSB = 14;
   localparam int POSITIVE_ONLY_ACCUMULATE_BIT = 15;
   localparam logic [1:0] WAVEFORM_SOURCE_SELECT_POWER = 2'h0;
   localparam logic [1:0] WAVEFORM_SOURCE_SELECT_RSVD = 2'h1;
   localparam logic [1:0] WAVEFORM_SOURCE_SELECT_CH1 = 2'h2;
   localparam logic [1:0] WAVEFORM_SOURCE_SELECT_CH2 = 2'h3;
   localparam logic [15:0] IRQ_EN_RST = 16'h0000;
   localparam logic [15:0] FLAG_USED = 16'h7fff;
   localparam logic [15:0] FLAG_IRQ_MASK = 16'h7fbf;
   localparam int FL_ACTIVE_ENERGY_HALF_FLAG = 0;
   localparam int FL_SAG = 1;
   localparam int FL_CYC = 2;
   localparam int FL_WAVE = 3;
   localparam int FL_ZX = 4;
   localparam int FL_TEMP = 5;
   localparam int FL_RESET = 6;
   localparam int FL_ACTIVE_ENERGY_OVERFLOW_FLAG = 7;
   localparam int FL_PKV = 8;
   localparam int FL_PKI = 9;
   localparam int FL_APPARENT_ENERGY_HALF_FLAG = 10;
   localparam int FL_APPARENT_ENERGY_OVERFLOW_FLAG = 11;
   localparam int FL_ZERO_CROSS_TIMEOUT_FLAG = 12;
   localparam int FL_POWER_GOES_POSITIVE_FLAG = 13;
   localparam int FL_POWER_GOES_NEGATIVE_FLAG = 14;
   localparam logic [7:0] CHANNEL_ONE_OFFSET_INTEGRATOR_RST = 8'h00;
   localparam logic [7:0] CHANNEL_ONE_OFFSET_INTEGRATOR_USED = 8'hbf;
   localparam int OFS_MAG_MSB = 4;
   localparam int OFS_SIGN_BIT = 5;
   localparam int INTEG_BIT = 7;
   typedef enum logic [1:0] {
      MIC_COMM = 2'h0,
      MIC_WR = 2'h1,
      MIC_RD = 2'h3
   } mic_ser_t;
endpackage

// ### verilog/mic_serial.sv
// Serial shifter for the communication byte and the register data that follows it.
`timescale 1ns/1ps
module mic_serial
   import mic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic [DATA_MAX-1:0] rd_data,
   input wire logic [LEN_W-1:0] rd_len,
   output logic cmd_valid,
   output logic [ADDR_W-1:0] cmd_addr,
   output logic cmd_write,
   output logic wr_valid,
   output logic [DATA_MAX-1:0] wr_data,
   output logic dout,
   output logic dout_oe
);
   mic_ser_t state;
   logic sclk_q;
   logic [LEN_W-1:0] cnt;
   logic [LEN_W-1:0] len;
   logic [DATA_MAX-1:0] shreg;
   wire fall = sclk_q & ~sclk;
   wire rise = ~sclk_q & sclk;
   wire last = (cnt + 5'h01) == len;
   wire [LEN_W-1:0] sh_amt = LEN_24 - rd_len;
   wire [DATA_MAX-1:0] rd_aligned = rd_data << sh_amt;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= MIC_COMM;
         sclk_q <= 1'b1;
         cnt <= '0;
         len <= COMM_LEN;
         shreg <= '0;
         cmd_valid <= 1'b0;
         cmd_addr <= '0;
         cmd_write <= 1'b0;
         wr_valid <= 1'b0;
         wr_data <= '0;
         dout <= 1'b0;
         dout_oe <= 1'b0;
      end else if (ce) begin
         sclk_q <= sclk;
         cmd_valid <= 1'b0;
         wr_valid <= 1'b0;
         dout_oe <= ~cs_n && state == MIC_RD;
         if (cs_n) begin
            state <= MIC_COMM;
            cnt <= '0;
            len <= COMM_LEN;
         end else if (cmd_valid) begin
            // Data phase length follows the addressed register.
            len <= rd_len;
            cnt <= '0;
            shreg <= rd_aligned;
            state <= cmd_write ? MIC_WR : MIC_RD;
         end else if (fall && state != MIC_RD) begin
            shreg <= {shreg[DATA_MAX-2:0], din};
            cnt <= last ? '0 : cnt + 5'h01;
            if (last && state == MIC_COMM) begin
               cmd_valid <= 1'b1;
               cmd_addr <= {shreg[ADDR_W-2:0], din};
               cmd_write <= shreg[CMD_WRITE_BIT-1];
            end else if (last) begin
               wr_valid <= 1'b1;
               wr_data <= {shreg[DATA_MAX-2:0], din};
               state <= MIC_COMM;
               len <= COMM_LEN;
            end
         end else if (fall) begin
            // The read phase ends on the host's last sampling edge so that a following command lines up.
            cnt <= last ? '0 : cnt + 5'h01;
            if (last) begin
               state <= MIC_COMM;
               len <= COMM_LEN;
            end
         end else if (rise && state == MIC_RD) begin
            dout <= shreg[DATA_MAX-1];
            shreg <= {shreg[DATA_MAX-2:0], 1'b0};
         end
      end
   end
endmodule

// ### verilog/mic_core.sv
// Mode, interrupt flag, interrupt enable and channel-one offset registers with their event logic.
`timescale 1ns/1ps
// Summary of operation
// - Mode bits 14:13 pick power, channel one or channel two for the waveform register.
// - Mode bit 15 set lets only positive power accumulate; clear allows both signs.
// - Every event sets its status flag whatever the enable says.
// - Interrupt output goes low while any enabled flag other than flag 6 is set.
// - Flag 6 marks end of hardware or software reset and never raises the interrupt.
// - Flag 0 on active energy half full, flag 7 on its overflow.
// - Flag 10 on apparent energy half full, flag 11 on its overflow.
// - Flag 1 on a line voltage sag.
// - Flag 2 when line-cycle accumulation completes.
// - Flag 3 when a new waveform sample is stored.
// - Flag 4 follows the zero-crossing level.
// - Flag 5 when a temperature result is ready.
// - Flag 8 when a channel-two sample exceeds the voltage peak threshold.
// - Flag 9 when a channel-one sample exceeds the current peak threshold.
// - Flag 12 on zero-crossing timeout.
// - Flag 13 power turns positive, flag 14 power turns negative, bit 15 reserved.
// - Offset bits 4:0 give magnitude, bit 5 the sign, for channel one.
// - Offset bit 7 turns on the channel-one integrator; bit 6 unused.
// - Communication byte holds address in bits 5:0 and write in bit 7.
module mic_core
   import mic_pkg::*;
#(
   parameter int SAMPLE_W = 24
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   output logic irq_pin_out,
   output logic irq_pin_oe,
   input wire logic sample_strobe,
   input wire logic [SAMPLE_W-1:0] power_sample,
   input wire logic [SAMPLE_W-1:0] ch1_sample,
   input wire logic [SAMPLE_W-1:0] ch2_sample,
   input wire logic [SAMPLE_W-1:0] voltage_peak_threshold,
   input wire logic [SAMPLE_W-1:0] current_peak_threshold,
   input wire logic active_energy_half_evt,
   input wire logic active_energy_ovf_evt,
   input wire logic apparent_energy_half_evt,
   input wire logic apparent_energy_ovf_evt,
   input wire logic sag_evt,
   input wire logic line_cycle_done_evt,
   input wire logic zero_cross_level,
   input wire logic temp_ready_evt,
   input wire logic zero_cross_timeout_evt,
   input wire logic power_pos_evt,
   input wire logic power_neg_evt,
   output logic [15:0] operating_configuration,
   output logic [7:0] channel_one_offset_integrator,
   output logic [SAMPLE_W-1:0] waveform_sample,
   output logic soft_reset_pulse
);
   logic [15:0] interrupt_enable;
   logic [15:0] flags;
   logic hw_rst_seen;
   logic cmd_valid;
   logic [ADDR_W-1:0] cmd_addr;
   logic cmd_write;
   logic wr_valid;
   logic [DATA_MAX-1:0] wr_data;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_MAX-1:0] rd_data;
   logic [LEN_W-1:0] rd_len;
   logic [15:0] ev;
   logic [15:0] next_flags;

   function automatic logic [SAMPLE_W-1:0] mag(input logic [SAMPLE_W-1:0] s);
      mag = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
   endfunction

   wire [1:0] waveform_source_select = operating_configuration[WAVEFORM_SOURCE_SELECT_MSB:WAVEFORM_SOURCE_SELECT_LSB];
   wire positive_only_accumulate = operating_configuration[POSITIVE_ONLY_ACCUMULATE_BIT];
   wire [OFS_MAG_MSB:0] offset_magnitude = channel_one_offset_integrator[OFS_MAG_MSB:0];
   wire offset_negative = channel_one_offset_integrator[OFS_SIGN_BIT];
   wire integrator_on = channel_one_offset_integrator[INTEG_BIT];
   wire wave_ok = waveform_source_select != WAVEFORM_SOURCE_SELECT_RSVD;
   wire [SAMPLE_W-1:0] wave_src = waveform_source_select == WAVEFORM_SOURCE_SELECT_CH1 ? ch1_sample :
      waveform_source_select == WAVEFORM_SOURCE_SELECT_CH2 ? ch2_sample : power_sample;
   wire wave_store = sample_strobe & wave_ok;
   wire pk_v = sample_strobe & (mag(ch2_sample) > voltage_peak_threshold);
   wire pk_i = sample_strobe & (mag(ch1_sample) > current_peak_threshold);
   wire wr_mode = wr_valid & wr_addr == ADR_MODE;
   wire swrst = wr_mode & wr_data[MODE_SWRST_BIT];
   wire rc_read = cmd_valid & ~cmd_write & cmd_addr == ADR_FLAGS_RC;
   wire irq_active = |(flags & interrupt_enable & FLAG_IRQ_MASK);

   mic_serial u_serial (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .sclk(sclk),
      .cs_n(cs_n),
      .din(din),
      .rd_data(rd_data),
      .rd_len(rd_len),
      .cmd_valid(cmd_valid),
      .cmd_addr(cmd_addr),
      .cmd_write(cmd_write),
      .wr_valid(wr_valid),
      .wr_data(wr_data),
      .dout(dout),
      .dout_oe(dout_oe)
   );

   always_comb begin
      rd_data = '0;
      rd_len = LEN_8;
      unique case (cmd_addr)
         ADR_WAVE: begin
            rd_data = DATA_MAX'(waveform_sample);
            rd_len = LEN_24;
         end
         ADR_MODE: begin
            rd_data = DATA_MAX'(operating_configuration);
            rd_len = LEN_16;
         end
         ADR_IRQ_EN: begin
            rd_data = DATA_MAX'(interrupt_enable);
            rd_len = LEN_16;
         end
         ADR_FLAGS, ADR_FLAGS_RC: begin
            rd_data = DATA_MAX'(flags);
            rd_len = LEN_16;
         end
         ADR_CHANNEL_ONE_OFFSET_INTEGRATOR: begin
            rd_data = DATA_MAX'(channel_one_offset_integrator);
         end
         default: begin
            rd_data = '0;
         end
      endcase
   end

   always_comb begin
      ev = '0;
      ev[FL_ACTIVE_ENERGY_HALF_FLAG] = active_energy_half_evt;
      ev[FL_ACTIVE_ENERGY_OVERFLOW_FLAG] = active_energy_ovf_evt;
      ev[FL_APPARENT_ENERGY_HALF_FLAG] = apparent_energy_half_evt;
      ev[FL_APPARENT_ENERGY_OVERFLOW_FLAG] = apparent_energy_ovf_evt;
      ev[FL_SAG] = sag_evt;
      ev[FL_CYC] = line_cycle_done_evt;
      ev[FL_WAVE] = wave_store;
      ev[FL_TEMP] = temp_ready_evt;
      ev[FL_RESET] = swrst | ~hw_rst_seen;
      ev[FL_PKV] = pk_v;
      ev[FL_PKI] = pk_i;
      ev[FL_ZERO_CROSS_TIMEOUT_FLAG] = zero_cross_timeout_evt;
      ev[FL_POWER_GOES_POSITIVE_FLAG] = power_pos_evt;
      ev[FL_POWER_GOES_NEGATIVE_FLAG] = power_neg_evt;
   end

   // Each flag except the zero-crossing flag 4 is set by its event, which wins over a simultaneous clear.
   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_flag
         if (i == FL_ZX) begin : g_level
            assign next_flags[i] = zero_cross_level;
         end else begin : g_sticky
            assign next_flags[i] = FLAG_USED[i] & (ev[i] | (flags[i] & ~rc_read & ~swrst));
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_addr <= '0;
      end else if (ce && cmd_valid) begin
         wr_addr <= cmd_addr;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags <= '0;
         hw_rst_seen <= 1'b0;
         irq_pin_out <= 1'b0;
         irq_pin_oe <= 1'b0;
         soft_reset_pulse <= 1'b0;
      end else if (ce) begin
         flags <= next_flags;
         hw_rst_seen <= 1'b1;
         irq_pin_oe <= irq_active;
         soft_reset_pulse <= swrst;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         operating_configuration <= MODE_RST;
         interrupt_enable <= IRQ_EN_RST;
         channel_one_offset_integrator <= CHANNEL_ONE_OFFSET_INTEGRATOR_RST;
      end else if (ce) begin
         if (swrst) begin
            operating_configuration <= MODE_RST;
            interrupt_enable <= IRQ_EN_RST;
            channel_one_offset_integrator <= CHANNEL_ONE_OFFSET_INTEGRATOR_RST;
         end else begin
            if (wr_mode) begin
               operating_configuration <= wr_data[15:0] & ~(16'h0001 << MODE_SWRST_BIT);
            end else if (temp_ready_evt) begin
               operating_configuration[MODE_TEMP_BIT] <= 1'b0;
            end
            if (wr_valid && wr_addr == ADR_IRQ_EN) begin
               interrupt_enable <= wr_data[15:0];
            end
            if (wr_valid && wr_addr == ADR_CHANNEL_ONE_OFFSET_INTEGRATOR) begin
               channel_one_offset_integrator <= wr_data[7:0] & CHANNEL_ONE_OFFSET_INTEGRATOR_USED;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         waveform_sample <= '0;
      end else if (ce && wave_store) begin
         waveform_sample <= wave_src;
      end
   end

   a_irq_follows_flags: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> irq_pin_oe == $past(irq_active)) else $error("irq enable does not follow enabled flags");
   a_reset_flag_quiet: assert property (@(posedge clk) disable iff (!rstn)
      (flags == 16'h0040) |=> !irq_pin_oe) else $error("reset flag raised the interrupt");
   a_event_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
      (ce && active_energy_ovf_evt) |=> flags[FL_ACTIVE_ENERGY_OVERFLOW_FLAG]) else $error("overflow flag not set");
   a_sag_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
      (ce && sag_evt) |=> flags[FL_SAG]) else $error("sag lost against clear");
   a_flag_holds: assert property (@(posedge clk) disable iff (!rstn)
      (ce && flags[FL_CYC] && !rc_read && !swrst) |=> flags[FL_CYC]) else $error("flag dropped without clear");
   a_rc_clears: assert property (@(posedge clk) disable iff (!rstn)
      (ce && rc_read && !ev[FL_TEMP] && !swrst) |=> !flags[FL_TEMP]) else $error("clear on read failed");
   a_zx_follows: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> flags[FL_ZX] == $past(zero_cross_level)) else $error("zero cross flag mismatch");
   a_wave_select: assert property (@(posedge clk) disable iff (!rstn)
      (ce && sample_strobe && waveform_source_select == WAVEFORM_SOURCE_SELECT_CH2) |=> waveform_sample == $past(ch2_sample)
      ##0 flags[FL_WAVE]) else $error("waveform source or flag wrong");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
      !flags[15] && !channel_one_offset_integrator[6]) else $error("reserved bit set");
   a_positive_only_accumulate_write: assert property (@(posedge clk) disable iff (!rstn)
      (ce && wr_mode && !swrst) |=> positive_only_accumulate == $past(wr_data[POSITIVE_ONLY_ACCUMULATE_BIT]))
      else $error("positive only bit not written");
   a_integ_write: assert property (@(posedge clk) disable iff (!rstn)
      (ce && wr_valid && wr_addr == ADR_CHANNEL_ONE_OFFSET_INTEGRATOR && !swrst) |=> integrator_on == $past(wr_data[INTEG_BIT])
      && offset_negative == $past(wr_data[OFS_SIGN_BIT]) && offset_magnitude == $past(wr_data[4:0]))
      else $error("offset register write wrong");
endmodule

// ### test/mic_host_model.sv
// Host microcontroller model that runs register transfers over the serial port.
`timescale 1ns/1ps
module mic_host_model (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b1;
   end
   task automatic put_bit(input logic b, output logic q);
      @(negedge clk);
      q = dout;
      din = b;
      sclk = 1'b0;
      repeat (3) @(negedge clk);
      sclk = 1'b1;
      repeat (3) @(negedge clk);
   endtask
   task automatic xfer(input logic wr, input logic [5:0] a, input int n, input logic [23:0] wd,
                       output logic [23:0] rd);
      logic [7:0] c;
      logic q;
      c = {wr, 1'b0, a};
      rd = 24'h000000;
      @(negedge clk);
      cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         put_bit(c[i], q);
      end
      for (int i = n - 1; i >= 0; i--) begin
         put_bit(wd[i], q);
         rd = {rd[22:0], q};
      end
      @(negedge clk);
      cs_n = 1'b1;
      din = ~din;
   endtask
endmodule

// ### test/meter_irq_and_config_regs_tb.sv
// Self-checking bench for the metering interrupt and configuration registers.
`timescale 1ns/1ps
module meter_irq_and_config_regs_tb;
   import mic_pkg::*;
   logic clk, rstn, ce, sclk, cs_n, din, dout, dout_oe, irq_pin_out, irq_pin_oe, strobe, zx, irq_n, srst;
   int srst_cnt, oe_cyc, oe_mark;
   logic [15:0] ev, mode;
   logic [7:0] ofs;
   logic [23:0] ps, c1, c2, vthr, ithr, wave, rd;
   int err_count, compares;
   int evl[10] = '{FL_ACTIVE_ENERGY_HALF_FLAG, FL_SAG, FL_CYC, FL_TEMP, FL_ACTIVE_ENERGY_OVERFLOW_FLAG, FL_APPARENT_ENERGY_HALF_FLAG, FL_APPARENT_ENERGY_OVERFLOW_FLAG, FL_ZERO_CROSS_TIMEOUT_FLAG, FL_POWER_GOES_POSITIVE_FLAG, FL_POWER_GOES_NEGATIVE_FLAG};
   logic [1:0] wsel[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   logic [23:0] wexp[4] = '{24'h000011, 24'h0000c8, 24'h000032, 24'h000032};
   logic wflag[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   assign irq_n = irq_pin_oe ? irq_pin_out : 1'b1;
   always @(posedge clk) begin
      if (srst === 1'b1) begin
         srst_cnt <= srst_cnt + 1;
      end
      if (dout_oe === 1'b1) begin
         oe_cyc <= oe_cyc + 1;
      end
   end
   always #25 clk = ~clk;
   mic_host_model host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   mic_core #(.SAMPLE_W(24)) dut_u (.clk(clk), .rstn(rstn), .ce(ce), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .dout_oe(dout_oe), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
      .sample_strobe(strobe), .power_sample(ps), .ch1_sample(c1), .ch2_sample(c2),
      .voltage_peak_threshold(vthr), .current_peak_threshold(ithr),
      .active_energy_half_evt(ev[FL_ACTIVE_ENERGY_HALF_FLAG]), .active_energy_ovf_evt(ev[FL_ACTIVE_ENERGY_OVERFLOW_FLAG]),
      .apparent_energy_half_evt(ev[FL_APPARENT_ENERGY_HALF_FLAG]), .apparent_energy_ovf_evt(ev[FL_APPARENT_ENERGY_OVERFLOW_FLAG]),
      .sag_evt(ev[FL_SAG]), .line_cycle_done_evt(ev[FL_CYC]), .zero_cross_level(zx),
      .temp_ready_evt(ev[FL_TEMP]), .zero_cross_timeout_evt(ev[FL_ZERO_CROSS_TIMEOUT_FLAG]), .power_pos_evt(ev[FL_POWER_GOES_POSITIVE_FLAG]),
      .power_neg_evt(ev[FL_POWER_GOES_NEGATIVE_FLAG]), .operating_configuration(mode), .channel_one_offset_integrator(ofs),
      .waveform_sample(wave), .soft_reset_pulse(srst));
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd_reg(input logic [5:0] a, input int n, input logic [23:0] exp, input string nm);
      host_u.xfer(1'b0, a, n, 24'h000000, rd);
      chk(nm, exp, rd);
   endtask
   task automatic wr_reg(input logic [5:0] a, input int n, input logic [23:0] wd);
      host_u.xfer(1'b1, a, n, wd, rd);
      repeat (2) @(negedge clk);
   endtask
   task automatic pulse(input int b);
      @(negedge clk);
      ev[b] = 1'b1;
      @(negedge clk);
      ev[b] = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic samp(input logic [23:0] p, input logic [23:0] a, input logic [23:0] b);
      @(negedge clk);
      ps = p;
      c1 = a;
      c2 = b;
      strobe = 1'b1;
      @(negedge clk);
      strobe = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic end_sim;
      $display("Comparisons: %0d, mismatches: %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      end_sim();
   end
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      ce = 1'b1;
      ev = 16'h0000;
      zx = 1'b0;
      strobe = 1'b0;
      ps = 24'h000000;
      c1 = 24'h000000;
      c2 = 24'h000000;
      vthr = 24'h000064;
      ithr = 24'h000064;
      err_count = 0;
      compares = 0;
      srst_cnt = 0;
      oe_cyc = 0;
      oe_mark = 0;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      chk("irq_after_reset", 24'h000001, {23'h0, irq_n});
      rd_reg(ADR_MODE, 16, 24'h00000c, "mode_reset");
      rd_reg(ADR_IRQ_EN, 16, 24'h000000, "enable_reset");
      rd_reg(ADR_CHANNEL_ONE_OFFSET_INTEGRATOR, 8, 24'h000000, "offset_reset");
      chk("read_drives_dout", 24'h000001, {23'h0, oe_cyc != 0});
      chk("dout_released", 24'h000000, {23'h0, dout_oe});
      oe_mark = oe_cyc;
      wr_reg(ADR_IRQ_EN, 16, 24'h000040);
      chk("write_leaves_dout", 24'(oe_mark), 24'(oe_cyc));
      chk("irq_reset_flag", 24'h000001, {23'h0, irq_n});
      rd_reg(ADR_FLAGS, 16, 24'h000040, "flags_reset");
      rd_reg(ADR_FLAGS_RC, 16, 24'h000040, "flags_rc_reset");
      rd_reg(ADR_FLAGS, 16, 24'h000000, "flags_cleared");
      wr_reg(ADR_IRQ_EN, 16, 24'h000001);
      foreach (evl[k]) begin
         pulse(evl[k]);
         chk("irq_level", {23'h0, evl[k] != 0}, {23'h0, irq_n});
         rd_reg(ADR_FLAGS, 16, 24'h1 << evl[k], "event_flag");
         rd_reg(ADR_FLAGS_RC, 16, 24'h1 << evl[k], "event_flag_rc");
         chk("irq_released", 24'h000001, {23'h0, irq_n});
      end
      zx = 1'b1;
      repeat (3) @(negedge clk);
      rd_reg(ADR_FLAGS, 16, 24'h000010, "zero_cross_high");
      zx = 1'b0;
      repeat (3) @(negedge clk);
      rd_reg(ADR_FLAGS, 16, 24'h000000, "zero_cross_low");
      foreach (wsel[k]) begin
         wr_reg(ADR_MODE, 16, {8'h0, 1'b0, wsel[k], 13'h000c});
         chk("mode_out", {8'h0, 1'b0, wsel[k], 13'h000c}, {8'h0, mode});
         samp(24'h000011, 24'h0000c8, 24'h000032);
         chk("waveform", wexp[k], wave);
         rd_reg(ADR_FLAGS_RC, 16, {14'h0, 1'b1, 5'h0, wflag[k], 3'h0}, "wave_flags");
      end
      samp(24'h000011, 24'h000005, 24'h00012c);
      rd_reg(ADR_FLAGS_RC, 16, 24'h000100, "voltage_peak");
      wr_reg(ADR_MODE, 16, 24'h00800c);
      rd_reg(ADR_MODE, 16, 24'h00800c, "positive_only");
      chk("positive_only_out", 24'h000001, {23'h0, mode[POSITIVE_ONLY_ACCUMULATE_BIT]});
      wr_reg(ADR_CHANNEL_ONE_OFFSET_INTEGRATOR, 8, 24'h0000ff);
      rd_reg(ADR_CHANNEL_ONE_OFFSET_INTEGRATOR, 8, 24'h0000bf, "offset_all_ones");
      chk("offset_out", 24'h0000bf, {16'h0, ofs});
      wr_reg(ADR_CHANNEL_ONE_OFFSET_INTEGRATOR, 8, 24'h000025);
      rd_reg(ADR_CHANNEL_ONE_OFFSET_INTEGRATOR, 8, 24'h000025, "offset_negative");
      wr_reg(ADR_FLAGS, 16, 24'h00ffff);
      rd_reg(ADR_FLAGS, 16, 24'h000000, "flags_read_only");
      rd_reg(6'h3f, 8, 24'h000000, "unmapped");
      wr_reg(ADR_IRQ_EN, 16, 24'h007fff);
      wr_reg(ADR_MODE, 16, 24'h000040);
      rd_reg(ADR_FLAGS, 16, 24'h000040, "soft_reset_flag");
      chk("irq_soft_reset", 24'h000001, {23'h0, irq_n});
      rd_reg(ADR_MODE, 16, 24'h00000c, "mode_after_soft");
      rd_reg(ADR_CHANNEL_ONE_OFFSET_INTEGRATOR, 8, 24'h000000, "offset_after_soft");
      chk("soft_reset_pulses", 24'h000001, 24'(srst_cnt));
      end_sim();
   end
endmodule
